/* File: rtl/nrs_host.sv */
`timescale 1ns/1ps
module nrs_host
	import nrs_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      rst,
	input  wire logic      cmd_valid,
	output logic           cmd_ready,
	input  wire nrs_cmd_t  cmd,
	output logic           data_valid,
	input  wire logic      data_ready,
	output logic [7:0]     data,
	output logic           cle,
	output logic           ale,
	output logic           ce_n,
	output logic           we_n,
	output logic           read_strobe_n,
	output logic [7:0]     io_out,
	output logic           io_oe,
	input  wire logic [7:0] io_in,
	input  wire logic      ready_busy_n_out
);
	typedef enum {ST_IDLE, ST_STEP, ST_WLOW, ST_WHIGH, ST_RLOW,
		ST_RHIGH} nrs_state_t;

	nrs_state_t  state;
	nrs_cmd_t    cmd_q;
	nrs_kind_t   kind;
	logic [3:0]  idx;
	logic [3:0]  cnt;
	logic [11:0] remain;
	logic [1:0]  pfx;
	logic [7:0]  byte_v;
	logic [2:0]  aidx;
	logic        apl;
	logic [23:0] arow;
	logic        rb_s1, rb_s2, rb_s3;
	logic        status_mode, tp_mode;
	logic        push;
	logic [7:0]  push_data;
	logic        skid_v;
	logic [7:0]  skid;
	logic [3:0]  addr_seen;

	// ************************************************************
	// ready/busy synchroniser
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
			rb_s3 <= 1'b0;
		end else begin
			rb_s1 <= ready_busy_n_out;
			rb_s2 <= rb_s1;
			rb_s3 <= rb_s2;
		end
	end

	// ************************************************************
	// step decode
	// ************************************************************
	always_comb begin
		kind   = K_END;
		byte_v = CMD_READ_SETUP;
		aidx   = 3'h0;
		apl    = cmd_q.plane;
		unique case (cmd_q.op)
		OP_PAGE_READ, OP_CACHE_RAND: begin
			if (idx == 4'h0) begin
				kind = K_CMD;
			end else if (idx <= 4'(ADDR_CYCLES)) begin
				kind = K_ADDR;
				aidx = 3'(idx - 4'h1);
			end else if (idx == 4'h6) begin
				kind   = K_CMD;
				byte_v = (cmd_q.op == OP_PAGE_READ) ? CMD_CONFIRM
					: CMD_CACHE_SEQ;
			end else if (idx == 4'h7) begin
				kind = K_WAIT;
			end
		end
		OP_CACHE_SEQ, OP_CACHE_LAST: begin
			if (idx == 4'h0) begin
				kind   = K_CMD;
				byte_v = (cmd_q.op == OP_CACHE_SEQ) ? CMD_CACHE_SEQ
					: CMD_CACHE_LAST;
			end else if (idx == 4'h1) begin
				kind = K_WAIT;
			end
		end
		OP_TWO_PLANE: begin
			if (idx == 4'h0 || idx == 4'h6) begin
				kind = K_CMD;
			end else if (idx <= 4'h5) begin
				kind = K_ADDR;
				aidx = 3'(idx - 4'h1);
				apl  = 1'b0;
			end else if (idx <= 4'hb) begin
				kind = K_ADDR;
				aidx = 3'(idx - 4'h7);
				apl  = 1'b1;
			end else if (idx == 4'hc) begin
				kind   = K_CMD;
				byte_v = CMD_CONFIRM;
			end else if (idx == 4'hd) begin
				kind = K_WAIT;
			end
		end
		OP_COL_CHANGE: begin
			if (idx == 4'h0) begin
				kind   = K_CMD;
				byte_v = CMD_COL_CHANGE;
			end else if (idx <= 4'(COL_CYCLES)) begin
				kind = K_ADDR;
				aidx = 3'(idx - 4'h1);
			end else if (idx == 4'h3) begin
				kind   = K_CMD;
				byte_v = CMD_COL_CONF;
			end
		end
		OP_PLANE_SEL: begin
			if (idx == 4'h0) begin
				kind   = K_CMD;
				byte_v = CMD_PLANE_SEL;
			end else if (idx <= 4'(ADDR_CYCLES)) begin
				kind = K_ADDR;
				aidx = 3'(idx - 4'h1);
			end else if (idx == 4'h6) begin
				kind   = K_CMD;
				byte_v = CMD_COL_CONF;
			end
		end
		OP_STATUS: begin
			if (idx == 4'h0) begin
				kind   = K_CMD;
				byte_v = CMD_STATUS;
			end else if (idx == 4'h1) begin
				kind = K_READ;
			end
		end
		OP_READ_DATA: begin
			// after a poll the output source must be switched back
			if (pfx == 2'h0) begin
				kind = (idx == 4'h0) ? K_READ : K_END;
			end else if (pfx == 2'h1) begin
				if (idx == 4'h0)
					kind = K_CMD;
				else if (idx == 4'h1)
					kind = K_READ;
			end else begin
				if (idx == 4'h0) begin
					kind   = K_CMD;
					byte_v = CMD_PLANE_SEL;
				end else if (idx <= 4'(ADDR_CYCLES)) begin
					kind = K_ADDR;
					aidx = 3'(idx - 4'h1);
				end else if (idx == 4'h6) begin
					kind   = K_CMD;
					byte_v = CMD_COL_CONF;
				end else if (idx == 4'h7) begin
					kind = K_READ;
				end
			end
		end
		default: kind = K_END;
		endcase
		arow            = cmd_q.row;
		arow[PLANE_BIT] = apl;
		if (kind == K_ADDR) begin
			unique case (aidx)
			3'h0:    byte_v = cmd_q.col[7:0];
			3'h1:    byte_v = cmd_q.col[15:8];
			3'h2:    byte_v = arow[7:0];
			3'h3:    byte_v = arow[15:8];
			default: byte_v = arow[23:16];
			endcase
		end
	end

	// ************************************************************
	// pin sequencer
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			state         <= ST_IDLE;
			cmd_q         <= '0;
			cmd_ready     <= 1'b0;
			idx           <= 4'h0;
			cnt           <= 4'h0;
			remain        <= 12'h000;
			pfx           <= 2'h0;
			cle           <= 1'b0;
			ale           <= 1'b0;
			ce_n          <= 1'b1;
			we_n          <= 1'b1;
			read_strobe_n <= 1'b1;
			io_out        <= 8'h00;
			io_oe         <= 1'b0;
			push          <= 1'b0;
			push_data     <= 8'h00;
		end else begin
			push <= 1'b0;
			unique case (state)
			ST_IDLE: begin
				cmd_ready <= 1'b1;
				ce_n      <= 1'b1;
				if (cmd_valid && cmd_ready) begin
					cmd_q     <= cmd;
					cmd_ready <= 1'b0;
					ce_n      <= 1'b0;
					idx       <= 4'h0;
					remain    <= (cmd.op == OP_STATUS) ? 12'h001 : cmd.count;
					pfx       <= status_mode ? (tp_mode ? 2'h2 : 2'h1) : 2'h0;
					state     <= ST_STEP;
				end
			end
			ST_STEP: begin
				unique case (kind)
				K_CMD, K_ADDR: begin
					cle    <= (kind == K_CMD);
					ale    <= (kind == K_ADDR);
					io_out <= byte_v;
					io_oe  <= 1'b1;
					we_n   <= 1'b0;
					cnt    <= 4'(T_WP_CYC - 1);
					state  <= ST_WLOW;
				end
				K_WAIT: begin
					// both late stages high: transfer is done
					if (rb_s2 && rb_s3)
						idx <= idx + 4'h1;
				end
				K_READ: begin
					if (remain == 12'h000) begin
						idx <= idx + 4'h1;
					end else if (!(data_valid && skid_v)) begin
						read_strobe_n <= 1'b0;
						cnt           <= 4'(T_RP_CYC - 1);
						state         <= ST_RLOW;
					end
				end
				default: state <= ST_IDLE;
				endcase
			end
			ST_WLOW: begin
				if (cnt == 4'h0) begin
					we_n <= 1'b1;
					cnt  <= cle ? 4'(T_GAP_CYC - 1) : 4'(T_WH_CYC - 1);
					state <= ST_WHIGH;
				end else begin
					cnt <= cnt - 4'h1;
				end
			end
			ST_WHIGH: begin
				if (cnt == 4'h0) begin
					cle   <= 1'b0;
					ale   <= 1'b0;
					io_oe <= 1'b0;
					idx   <= idx + 4'h1;
					state <= ST_STEP;
				end else begin
					cnt <= cnt - 4'h1;
				end
			end
			ST_RLOW: begin
				if (cnt == 4'h0) begin
					read_strobe_n <= 1'b1;
					push          <= 1'b1;
					push_data     <= io_in;
					remain        <= remain - 12'h001;
					cnt           <= 4'(T_REH_CYC - 1);
					state         <= ST_RHIGH;
				end else begin
					cnt <= cnt - 4'h1;
				end
			end
			ST_RHIGH: begin
				if (cnt == 4'h0)
					state <= ST_STEP;
				else
					cnt <= cnt - 4'h1;
			end
			endcase
		end
	end

	// ************************************************************
	// output source tracking
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			status_mode <= 1'b0;
			tp_mode     <= 1'b0;
		end else if (state == ST_STEP && kind == K_CMD) begin
			if (byte_v == CMD_STATUS)
				status_mode <= 1'b1;
			else
				status_mode <= 1'b0;
			if (byte_v == CMD_CONFIRM)
				tp_mode <= (cmd_q.op == OP_TWO_PLANE);
			else if (byte_v == CMD_CACHE_SEQ || byte_v == CMD_CACHE_LAST)
				tp_mode <= 1'b0;
		end
	end

	// ************************************************************
	// two-entry output buffer
	// ************************************************************
	// a read starts only with a free slot, so a stall loses no byte
	always_ff @(posedge mclk) begin
		if (rst) begin
			data_valid <= 1'b0;
			data       <= 8'h00;
			skid_v     <= 1'b0;
			skid       <= 8'h00;
		end else begin
			if (!data_valid || data_ready) begin
				data_valid <= skid_v || push;
				data       <= skid_v ? skid : push_data;
				skid_v     <= skid_v && push;
				if (skid_v && push)
					skid <= push_data;
			end else if (push) begin
				skid_v <= 1'b1;
				skid   <= push_data;
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (rst)
			addr_seen <= 4'h0;
		else if (!we_n && cle)
			addr_seen <= 4'h0;
		else if (!we_n && ale && state == ST_WLOW && cnt == 4'h0)
			addr_seen <= addr_seen + 4'h1;
	end

	a_latch_exclusive: assert property (
		@(posedge mclk) disable iff (rst) !(cle && ale))
		else $error("command and address latch both high");
	a_strobe_drives: assert property (
		@(posedge mclk) disable iff (rst) !we_n |-> io_oe && !ce_n)
		else $error("write strobe without drive");
	a_confirm_addr: assert property (
		@(posedge mclk) disable iff (rst)
		$fell(we_n) && cle && io_out == CMD_CONFIRM |->
		addr_seen == 4'h5 || addr_seen == 4'ha)
		else $error("confirm without full address");
	a_col_conf_addr: assert property (
		@(posedge mclk) disable iff (rst)
		$fell(we_n) && cle && io_out == CMD_COL_CONF |->
		addr_seen == 4'h2 || addr_seen == 4'h5)
		else $error("column confirm with wrong address count");
	a_no_enh_status: assert property (
		@(posedge mclk) disable iff (rst)
		!we_n && cle |-> io_out != CMD_STATUS_ENH)
		else $error("enhanced status issued");
	a_read_not_busy: assert property (
		@(posedge mclk) disable iff (rst)
		$fell(read_strobe_n) |-> rb_s3 && !io_oe)
		else $error("read strobe while busy or driving");
	a_status_resetup: assert property (
		@(posedge mclk) disable iff (rst)
		$fell(read_strobe_n) && cmd_q.op == OP_READ_DATA |-> !status_mode)
		else $error("data read while status selected");
	a_buffer_noloss: assert property (
		@(posedge mclk) disable iff (rst)
		push |-> !(data_valid && skid_v && !data_ready))
		else $error("push into full buffer");
	a_strobe_width: assert property (
		@(posedge mclk) disable iff (rst)
		$fell(we_n) |-> !we_n ##1 we_n ##1 we_n)
		else $error("write strobe timing wrong");
endmodule // nrs_host

/* File: rtl/nrs_pkg.sv */
package nrs_pkg;
	// ************************************************************
	// clock and strobe timing
	// ************************************************************
	localparam int CLK_NS     = 50;
	localparam int T_WP_NS    = 25;
	localparam int T_WH_NS    = 15;
	localparam int T_WB_NS    = 100;
	localparam int T_WHR_NS   = 60;
	localparam int T_RP_NS    = 25;
	localparam int T_REH_NS   = 15;
	localparam int T_WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_WH_CYC   = (T_WH_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_WB_CYC   = (T_WB_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_WHR_CYC  = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RP_CYC   = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_REH_CYC  = (T_REH_NS + CLK_NS - 1) / CLK_NS;
	// a command may be followed by a busy wait or a data read
	localparam int T_GAP_CYC  = (T_WB_CYC > T_WHR_CYC) ? T_WB_CYC : T_WHR_CYC;

	// ************************************************************
	// command codes and address layout
	// ************************************************************
	localparam logic [7:0] CMD_READ_SETUP = 8'h00;
	localparam logic [7:0] CMD_CONFIRM    = 8'h30;
	localparam logic [7:0] CMD_CACHE_SEQ  = 8'h31;
	localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
	localparam logic [7:0] CMD_COL_CHANGE = 8'h05;
	localparam logic [7:0] CMD_PLANE_SEL  = 8'h06;
	localparam logic [7:0] CMD_COL_CONF   = 8'he0;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
	localparam int         PLANE_BIT      = 6;
	localparam int         ADDR_CYCLES    = 5;
	localparam int         COL_CYCLES     = 2;
	localparam int         BUF_DEPTH      = 2;

	typedef enum logic [3:0] {
		OP_PAGE_READ, OP_CACHE_SEQ, OP_CACHE_RAND, OP_CACHE_LAST,
		OP_TWO_PLANE, OP_COL_CHANGE, OP_PLANE_SEL, OP_STATUS,
		OP_READ_DATA
	} nrs_op_t;

	typedef enum logic [2:0] {
		K_CMD, K_ADDR, K_WAIT, K_READ, K_END
	} nrs_kind_t;

	typedef struct packed {
		nrs_op_t      op;
		logic [23:0]  row;
		logic [15:0]  col;
		logic         plane;
		logic [11:0]  count;
	} nrs_cmd_t;
endpackage

/* File: tb/nrs_flash_model.sv */
`timescale 1ns/1ps
module nrs_flash_model
	import nrs_pkg::*;
#(
	parameter int ARRAY_READ_TIME_NS = 2000,
	parameter int CACHE_BUSY_TIME_NS = 1000
)(
	input  wire logic       ce_n,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       read_strobe_n,
	input  wire logic [7:0] io_out,
	input  wire logic       io_oe,
	output logic      [7:0] io_in,
	output logic            ready_busy_n_out,
	output logic            bad
);
	logic [7:0]  ab [0:4];
	logic [7:0]  last;
	logic [23:0] row_p [0:1];
	logic [23:0] prow, sel, nrow;
	logic [15:0] col;
	logic [7:0]  stat;
	logic        src_stat, arr, tp;
	int          acnt, np, bt;
	event        go;

	function automatic logic [7:0] pat(input logic [23:0] r,
		input logic [15:0] c);
		return r[7:0] ^ c[7:0] ^ c[15:8];
	endfunction

	// ********
	// command and address capture
	// ********
	initial begin
		io_in = 8'h5a;
		ready_busy_n_out = 1'b1;
		bad = 1'b0;
		acnt = 0;
		np = 0;
		src_stat = 1'b0;
		arr = 1'b1;
		tp = 1'b0;
		last = CMD_READ_SETUP;
	end

	always @(go) begin
		ready_busy_n_out = 1'b0;
		#(bt);
		ready_busy_n_out = 1'b1;
	end

	task automatic do_cmd(input logic [7:0] c);
		nrow = {ab[4], ab[3], ab[2]};
		case (c)
			CMD_READ_SETUP: begin
				src_stat = 1'b0;
				np = (acnt == ADDR_CYCLES) ? 1 : 0;
				prow = nrow;
			end
			CMD_CONFIRM: begin
				if (np == 1) begin
					if ((prow ^ nrow) != (24'h1 << PLANE_BIT))
						bad = 1'b1;
					row_p[prow[PLANE_BIT]] = prow;
					row_p[nrow[PLANE_BIT]] = nrow;
					tp = 1'b1;
				end else begin
					row_p[0] = nrow;
					sel = nrow;
					col = {ab[1], ab[0]};
					tp = 1'b0;
				end
				arr = 1'b1;
				bt = ARRAY_READ_TIME_NS;
				->go;
			end
			CMD_CACHE_SEQ: begin
				sel = row_p[0];
				// column bytes of a random cache address are ignored
				if (acnt == ADDR_CYCLES)
					row_p[0] = nrow;
				else
					row_p[0] = sel + 24'h1;
				col = 16'h0000;
				arr = 1'b0;
				tp = 1'b0;
				bt = CACHE_BUSY_TIME_NS;
				->go;
			end
			CMD_CACHE_LAST: begin
				sel = row_p[0];
				col = 16'h0000;
				arr = 1'b1;
				tp = 1'b0;
				bt = CACHE_BUSY_TIME_NS;
				->go;
			end
			CMD_COL_CONF: begin
				col = {ab[1], ab[0]};
				src_stat = 1'b0;
				if (last == CMD_PLANE_SEL)
					sel = row_p[nrow[PLANE_BIT]];
			end
			CMD_STATUS: src_stat = 1'b1;
			CMD_STATUS_ENH: if (tp) bad = 1'b1;
			default: ;
		endcase
		if (c != CMD_READ_SETUP)
			np = 0;
		last = c;
		acnt = 0;
	endtask

	always @(posedge we_n) begin
		if (!ce_n) begin
			if (!io_oe && (cle || ale))
				bad = 1'b1;
			if (ale && !cle) begin
				if (acnt < ADDR_CYCLES)
					ab[acnt] = io_out;
				acnt++;
			end else if (cle && !ale)
				do_cmd(io_out);
		end
	end

	// ********
	// data output
	// ********
	assign stat = {1'b0, ready_busy_n_out,
		ready_busy_n_out & arr, 5'h00};

	always @(negedge read_strobe_n) begin
		if (!ce_n)
			io_in = src_stat ? stat : pat(sel, col);
	end

	// after the hold time the bus shows junk, never the last byte
	always @(posedge read_strobe_n) begin
		if (!src_stat)
			col = col + 16'h1;
		#5;
		io_in = ~io_in;
	end
endmodule // nrs_flash_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import nrs_pkg::*;
;
	logic       mclk, rst, cmd_valid, cmd_ready, data_valid, data_ready;
	nrs_cmd_t   cmd;
	logic [7:0] data, io_out, io_in;
	logic       cle, ale, ce_n, we_n, read_strobe_n, io_oe, rb, bad;
	int         mismatches, cmp_count;
	localparam logic [23:0] R0 = 24'h000123;
	localparam logic [23:0] R2 = 24'h000200;
	localparam logic [23:0] R3 = 24'h000305;

	nrs_host DUT (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .data_valid(data_valid),
		.data_ready(data_ready), .data(data), .cle(cle), .ale(ale),
		.ce_n(ce_n), .we_n(we_n), .read_strobe_n(read_strobe_n),
		.io_out(io_out), .io_oe(io_oe), .io_in(io_in),
		.ready_busy_n_out(rb));
	nrs_flash_model u_flash (.ce_n(ce_n), .cle(cle), .ale(ale),
		.we_n(we_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
		.io_oe(io_oe), .io_in(io_in), .ready_busy_n_out(rb), .bad(bad));

	// ********
	// helpers
	// ********
	always #(CLK_NS / 2) mclk = ~mclk;

	function automatic logic [7:0] pat(input logic [23:0] r,
		input logic [15:0] c);
		return r[7:0] ^ c[7:0] ^ c[15:8];
	endfunction

	task automatic clk();
		@(posedge mclk);
		#1;
	endtask

	task automatic chk8(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		chk8(nm, {7'h00, e}, {7'h00, g});
	endtask

	task automatic close_out();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic send(input nrs_op_t op, input logic [23:0] r,
		input logic [15:0] c, input logic p, input logic [11:0] n);
		int k;
		cmd = '{op, r, c, p, n};
		cmd_valid = 1'b1;
		for (k = 0; k < 4000 && cmd_ready !== 1'b1; k++)
			clk();
		chk1("cmd_ready", 1'b1, cmd_ready);
		clk();
		cmd_valid = 1'b0;
		// one idle edge, so a following call never re-raises valid at once
		clk();
	endtask

	task automatic get_byte(output logic [7:0] b);
		int k;
		for (k = 0; k < 4000 && data_valid !== 1'b1; k++)
			clk();
		chk1("data_valid", 1'b1, data_valid);
		b = data;
		clk();
	endtask

	task automatic rd_chk(input logic [23:0] r, input logic [15:0] c,
		input logic p, input int n, input bit stall);
		logic [7:0] b;
		send(OP_READ_DATA, r, c, p, n[11:0]);
		if (stall) begin
			data_ready = 1'b0;
			repeat (40) clk();
			chk1("stalled data_valid", 1'b1, data_valid);
			data_ready = 1'b1;
		end
		for (int i = 0; i < n; i++) begin
			get_byte(b);
			chk8("page byte", pat(r, c + 16'(i)), b);
		end
	endtask

	task automatic st_chk(input logic [7:0] e);
		logic [7:0] b;
		send(OP_STATUS, 24'h0, 16'h0, 1'b0, 12'h000);
		get_byte(b);
		chk8("status", e, b);
	endtask

	// ********
	// scenarios
	// ********
	task automatic t_page();
		send(OP_PAGE_READ, R0, 16'h0010, 1'b0, 12'h000);
		rd_chk(R0, 16'h0010, 1'b0, 5, 1'b1);
	endtask

	task automatic t_col();
		logic [15:0] cols [2];
		cols = '{16'h0700, 16'h0003};
		st_chk(8'h60);
		rd_chk(R0, 16'h0015, 1'b0, 2, 1'b0);
		foreach (cols[i]) begin
			send(OP_COL_CHANGE, R0, cols[i], 1'b0, 12'h000);
			rd_chk(R0, cols[i], 1'b0, 3, 1'b0);
		end
	endtask

	task automatic t_cache();
		send(OP_CACHE_SEQ, R0, 16'h0, 1'b0, 12'h000);
		rd_chk(R0, 16'h0000, 1'b0, 2, 1'b0);
		st_chk(8'h40);
		rd_chk(R0, 16'h0002, 1'b0, 2, 1'b0);
		send(OP_CACHE_RAND, R2, 16'h0033, 1'b0, 12'h000);
		rd_chk(R0 + 24'h1, 16'h0000, 1'b0, 2, 1'b0);
		send(OP_CACHE_LAST, R0, 16'h0, 1'b0, 12'h000);
		rd_chk(R2, 16'h0000, 1'b0, 2, 1'b0);
		st_chk(8'h60);
	endtask

	task automatic t_plane();
		send(OP_TWO_PLANE, R3, 16'h0020, 1'b0, 12'h000);
		st_chk(8'h60);
		rd_chk(R3, 16'h0020, 1'b0, 2, 1'b0);
		send(OP_PLANE_SEL, R3, 16'h0040, 1'b1, 12'h000);
		rd_chk(R3 | 24'h40, 16'h0040, 1'b1, 2, 1'b0);
		chk1("flash flags", 1'b0, bad);
	endtask

	initial begin
		#2000000;
		mismatches++;
		close_out();
	end

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		data_ready = 1'b1;
		mismatches = 0;
		cmp_count = 0;
		repeat (10) clk();
		rst = 1'b0;
		clk();
		t_page();
		t_col();
		t_cache();
		t_plane();
		close_out();
	end
endmodule // tb_top
